// ### hw/tmx_consts.svh
// offsets, bit positions, reset values, status codes and timing for the two-wire master
`ifndef TMX_CONSTS_SVH
`define TMX_CONSTS_SVH
`define TMX_OFS_CTRL   8'h00
`define TMX_OFS_STAT   8'h04
`define TMX_OFS_DATA   8'h08
`define TMX_B_FLAG     7
`define TMX_B_ACKEN    6
`define TMX_B_STA      5
`define TMX_B_STO      4
`define TMX_B_WCOL     3
`define TMX_B_EN       2
`define TMX_B_IRQEN    0
`define TMX_DATA_RST   8'hff
`define TMX_ST_START   8'h08
`define TMX_ST_RSTART  8'h10
`define TMX_ST_AACK    8'h18
`define TMX_ST_ANAK    8'h20
`define TMX_ST_DACK    8'h28
`define TMX_ST_DNAK    8'h30
`define TMX_ST_LOST    8'h38
`define TMX_ST_RAACK   8'h40
`define TMX_ST_RANAK   8'h48
`define TMX_ST_RDACK   8'h50
`define TMX_ST_RDNAK   8'h58
`define TMX_ST_NONE    8'hf8
`define TMX_QTR_NS     2500
`define TMX_CLK_NS     100
`define TMX_QTR_CYC    ((`TMX_QTR_NS + `TMX_CLK_NS - 1) / `TMX_CLK_NS)
`endif

// ### hw/tmx_pkg.sv
// types shared by the two-wire master
`default_nettype none
package tmx_pkg;
  typedef enum logic [5:0] {
    S_IDLE  = 6'b000001,
    S_WAIT  = 6'b000010,
    S_START = 6'b000100,
    S_BITS  = 6'b001000,
    S_STOP  = 6'b010000,
    S_HOLD  = 6'b100000
  } tmx_state_t;
  typedef struct packed {
    logic scl_oe;
    logic sda_oe;
  } tmx_drive_t;
endpackage
`default_nettype wire

// ### hw/tmx_master.sv
// two-wire bus master transmitter with apb registers
// What this block does
// RQ1: four modes exist; here master transmit, and receive after a read address
// RQ2: address bit zero low keeps transmit mode, high selects receive mode
// RQ3: status codes sit in bits 7:3, prescaler bits read separately
// RQ4: bus transfer halts while the complete flag is set
// RQ5: software clears the flag by writing one with the next command
// RQ6: software sets the enable bit in every control write
// RQ7: start request waits for a free bus, then drives START
// RQ8: after START the flag sets with status 0x08
// RQ9: at 0x08 software loads address; block sends it and samples acknowledge
// RQ10: after address byte report 0x18, 0x20 or 0x38
// RQ11: data write while flag low is dropped and sets write collision
// RQ12: at 0x18 or 0x20 a loaded byte is sent and acknowledge sampled
// RQ13: start request alone sends repeated START, status 0x10
// RQ14: stop request alone sends STOP and clears the stop bit
// RQ15: both requests send STOP then START, stop bit cleared
// RQ16: at 0x10 write address keeps transmit, read address switches receive
// RQ17: repeated START keeps bus ownership, no STOP in between
// RQ18: after a refused address the same four responses apply
// RQ19: after data report 0x28 or 0x30, same four responses
// RQ20: lost arbitration reports 0x38, releases bus, may restart later
// RQ21: clock line held low while the flag is set; the code releases it after lost arbitration (0x38)
// RQ22: no flag after a STOP
// RQ23: reset leaves engine idle, bits clear, both lines released
`timescale 1ns/100ps
`default_nettype none
`include "tmx_consts.svh"
module tmx_master
  import tmx_pkg::*;
#(
  parameter int QTR_CYC = `TMX_QTR_CYC
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        scl_in,
  output logic             scl_out,
  output logic             scl_oe,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe,
  output logic             rx_mode
);
  tmx_state_t state;
  tmx_drive_t drv;
  logic       scl_m, scl_s, scl_d, sda_m, sda_s, sda_d;
  logic       busy, flag, acken, start_req_bit, stop_req_bit, wcol, en, irqen;
  logic [1:0] presc, q;
  logic [7:0] status, data, shreg;
  logic [3:0] bitn;
  logic       own, addr_ph, mr, ackbit;
  logic [15:0] qcnt;

  // line synchronisers; the first stage feeds nothing but the second
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {scl_m, scl_s, scl_d, sda_m, sda_s, sda_d} <= 6'h3f;
    end else begin
      {scl_m, scl_s, scl_d} <= {scl_in, scl_m, scl_s};
      {sda_m, sda_s, sda_d} <= {sda_in, sda_m, sda_s};
    end
  end

  // bus busy from seen START and STOP conditions
  wire seen_start = scl_s & scl_d & sda_d & ~sda_s;
  wire seen_stop  = scl_s & scl_d & ~sda_d & sda_s;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) busy <= 1'b0;
    else if (seen_start) busy <= 1'b1;
    else if (seen_stop) busy <= 1'b0;
  end

  // apb decode; zero wait states, unmapped addresses answer with an error
  wire hit_c   = paddr == `TMX_OFS_CTRL;
  wire hit_s   = paddr == `TMX_OFS_STAT;
  wire hit_d   = paddr == `TMX_OFS_DATA;
  wire acc     = psel & penable;
  wire wr_ctrl = acc & pwrite & hit_c;
  wire wr_stat = acc & pwrite & hit_s;
  wire wr_data = acc & pwrite & hit_d;
  assign pready  = 1'b1;
  assign pslverr = acc & ~(hit_c | hit_s | hit_d);
  wire [7:0] ctrl_v = {flag, acken, start_req_bit, stop_req_bit, wcol, en, 1'b0, irqen};
  wire [7:0] stat_v = {status[7:3], 1'b0, presc}; // [RQ3]
  wire [7:0] rd_v   = hit_c ? ctrl_v : hit_s ? stat_v : hit_d ? data : 8'h00;

  // read data is captured in the setup cycle so it comes from a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) prdata <= 32'h0;
    else if (psel & ~penable) prdata <= {24'h0, rd_v};
  end

  // command: flag cleared by writing one together with enable and requests
  wire w_sta = pwdata[`TMX_B_STA];
  wire w_sto = pwdata[`TMX_B_STO];
  wire go    = wr_ctrl & pwdata[`TMX_B_FLAG] & pwdata[`TMX_B_EN]
             & (flag | (state == S_IDLE & w_sta)); // [RQ5] [RQ6]
  wire dis   = wr_ctrl & ~pwdata[`TMX_B_EN];

  // quarter-bit enable; the quarter after the clock release stalls until the line reads high,
  // so neither a stretching slave nor our own held-low clock can be overrun
  wire tick  = qcnt == 16'h0;
  wire adv   = tick & ((q != 2'h2) | scl_s);
  wire rxd   = mr & ~addr_ph;
  wire last  = bitn == 4'd8;
  wire obit  = last ? (rxd ? ~acken : 1'b1) : (rxd ? 1'b1 : shreg[7]);
  wire q3    = adv & (q == 2'd3);
  wire lose  = state == S_BITS & adv & q == 2'd2 & obit & ~sda_s
             & (last == rxd); // [RQ20]
  wire fin   = state == S_BITS & q3 & last;
  wire st_dn = state == S_START & q3;
  wire sp_dn = state == S_STOP & q3;
  wire ack   = ~ackbit;
  wire [7:0] a_code = shreg[0] ? (ack ? `TMX_ST_RAACK : `TMX_ST_RANAK)
                               : (ack ? `TMX_ST_AACK : `TMX_ST_ANAK); // [RQ10]
  wire [7:0] d_code = rxd ? (acken ? `TMX_ST_RDACK : `TMX_ST_RDNAK)
                          : (ack ? `TMX_ST_DACK : `TMX_ST_DNAK); // [RQ19]
  wire hw_set = st_dn | fin | (lose & ~fin);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) qcnt <= 16'h0;
    else if (tick | state == S_IDLE | state == S_HOLD) qcnt <= 16'(QTR_CYC - 1);
    else qcnt <= qcnt - 16'h1;
  end

  // control bits; a hardware set beats a software clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin // [RQ23]
      {flag, acken, start_req_bit, stop_req_bit, wcol, en, irqen} <= 7'h0;
    end else begin
      flag <= hw_set | (flag & ~go & ~dis); // [RQ4]
      if (wr_ctrl) begin
        {acken, start_req_bit, en, irqen} <= {pwdata[`TMX_B_ACKEN], w_sta, pwdata[`TMX_B_EN], pwdata[`TMX_B_IRQEN]};
      end
      if (sp_dn) stop_req_bit <= 1'b0; // [RQ14] [RQ15]
      else if (wr_ctrl) stop_req_bit <= w_sto;
      if (wr_data) wcol <= ~flag; // [RQ11]
    end
  end

  // status register: prescaler bits are plain storage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) presc <= 2'h0;
    else if (wr_stat) presc <= pwdata[1:0];
  end

  // byte engine: START, nine clocked bits, STOP, hold with clock low except after lost arbitration
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state   <= S_IDLE;
      drv     <= '0;
      q       <= 2'd0;
      bitn    <= 4'd0;
      own     <= 1'b0;
      addr_ph <= 1'b0;
      mr      <= 1'b0;
      ackbit  <= 1'b1;
      shreg   <= 8'h0;
      data    <= `TMX_DATA_RST;
      status  <= `TMX_ST_NONE;
    end else if (dis) begin
      state <= S_IDLE;
      drv   <= '0;
      own   <= 1'b0;
      mr    <= 1'b0;
    end else begin
      if (wr_data & flag) data <= pwdata[7:0];
      if (go) status <= `TMX_ST_NONE;
      unique case (state)
        S_IDLE, S_HOLD: begin
          q    <= 2'd0;
          bitn <= 4'd0;
          if (go) begin
            if (!own) begin
              state <= w_sta ? S_WAIT : S_IDLE; // [RQ7] [RQ20]
              drv   <= '0;
            end else if (w_sto) begin
              state <= S_STOP; // [RQ14] [RQ15]
            end else if (w_sta) begin
              state <= S_START; // [RQ13] [RQ17]
            end else begin
              state <= S_BITS; // [RQ9] [RQ12] [RQ18]
              shreg <= data;
            end
          end
        end
        S_WAIT: begin
          if (!busy) state <= S_START; // [RQ7]
        end
        S_START: begin
          if (adv) begin
            q <= q + 2'd1;
            unique case (q)
              2'd0: drv.sda_oe <= 1'b0;
              2'd1: drv.scl_oe <= 1'b0;
              2'd2: drv.sda_oe <= 1'b1;
              2'd3: drv.scl_oe <= 1'b1;
            endcase
          end
          if (st_dn) begin
            status  <= own ? `TMX_ST_RSTART : `TMX_ST_START; // [RQ8] [RQ13]
            own     <= 1'b1;
            addr_ph <= 1'b1;
            state   <= S_HOLD;
          end
        end
        S_BITS: begin
          if (adv) begin
            q <= q + 2'd1;
            unique case (q)
              2'd0: drv.sda_oe <= ~obit;
              2'd1: drv.scl_oe <= 1'b0;
              2'd2: if (last) ackbit <= sda_s;
              2'd3: drv.scl_oe <= 1'b1;
            endcase
            if (q == 2'd3 & !last) begin
              shreg <= {shreg[6:0], sda_s};
              bitn  <= bitn + 4'd1;
            end
          end
          if (lose) begin
            state  <= S_HOLD;
            status <= `TMX_ST_LOST; // [RQ20]
            own    <= 1'b0;
            mr     <= 1'b0;
            drv    <= '0;
          end else if (fin) begin
            state   <= S_HOLD;
            addr_ph <= 1'b0;
            drv.sda_oe <= 1'b0;
            if (addr_ph) begin
              mr     <= shreg[0]; // [RQ1] [RQ2] [RQ16]
              status <= a_code;
            end else begin
              status <= d_code;
              if (rxd) data <= shreg;
            end
          end
        end
        S_STOP: begin
          if (adv) begin
            q <= q + 2'd1;
            unique case (q)
              2'd0: drv <= '{scl_oe: 1'b1, sda_oe: 1'b1};
              2'd1: drv.scl_oe <= 1'b0;
              2'd2: drv.sda_oe <= 1'b0;
              2'd3: drv <= '0;
            endcase
          end
          if (sp_dn) begin
            own   <= 1'b0;
            mr    <= 1'b0;
            state <= start_req_bit ? S_WAIT : S_IDLE; // [RQ15] [RQ22]
          end
        end
      endcase
    end
  end

  // open-drain pins: only ever pull low
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign scl_oe  = drv.scl_oe; // [RQ21]
  assign sda_oe  = drv.sda_oe;
  assign rx_mode = mr;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_start_done;
    st_dn;
  endsequence
  sequence s_addr_w;
    fin && addr_ph && !shreg[0];
  endsequence
  property p_start_code;
    s_start_done |=> flag && (status == `TMX_ST_START || status == `TMX_ST_RSTART);
  endproperty
  a_start_code: assert property (p_start_code) else $error("no flag or code after START"); // [RQ8]
  property p_rstart;
    s_start_done and own |=> status == `TMX_ST_RSTART && own;
  endproperty
  a_rstart: assert property (p_rstart) else $error("repeated START code wrong"); // [RQ13]
  property p_addr_code;
    s_addr_w |=> flag && (status == `TMX_ST_AACK || status == `TMX_ST_ANAK) && !mr;
  endproperty
  a_addr_code: assert property (p_addr_code) else $error("address status wrong"); // [RQ10]
  property p_mode;
    fin && addr_ph |=> mr == $past(shreg[0]);
  endproperty
  a_mode: assert property (p_mode) else $error("mode not from address bit"); // [RQ2]
  property p_suspend;
    flag && en |-> state == S_HOLD && qcnt == 16'(QTR_CYC - 1);
  endproperty
  a_suspend: assert property (p_suspend) else $error("engine ran with flag set"); // [RQ4]
  property p_scl_held;
    flag && own |-> scl_oe;
  endproperty
  a_scl_held: assert property (p_scl_held) else $error("clock released with flag set"); // [RQ21]
  property p_wcol;
    wr_data && !flag |=> wcol && $stable(data);
  endproperty
  a_wcol: assert property (p_wcol) else $error("write collision missed"); // [RQ11]
  property p_stop_end;
    sp_dn |=> !flag && !stop_req_bit && !own && !scl_oe && !sda_oe;
  endproperty
  a_stop_end: assert property (p_stop_end) else $error("STOP end state wrong"); // [RQ22]
  property p_lost;
    lose |=> status == `TMX_ST_LOST && flag && !scl_oe && !sda_oe;
  endproperty
  a_lost: assert property (p_lost) else $error("arbitration loss not handled"); // [RQ20]
endmodule // tmx_master
`default_nettype wire

// ### tb/tmx_slave_model.sv
// slave receiver model on the two-wire bus
`timescale 1ns/100ps
`default_nettype none
module tmx_slave_model #(
  parameter logic [6:0] ADDR = 7'h2a
) (
  input  wire logic       pclk,
  input  wire logic       scl,
  input  wire logic       sda,
  output logic            sda_oe,
  output logic [7:0]      last_byte
);
  logic       ps;
  logic       pd;
  logic       first;
  logic [3:0] cnt;
  logic [7:0] sh;
  initial begin
    sda_oe = 1'b0;
    cnt = 4'h0;
    first = 1'b0;
  end
  // a start resets framing; only the ninth bit is ever driven
  always @(posedge pclk) begin
    ps <= scl;
    pd <= sda;
    if (ps && scl && pd && !sda) begin
      cnt <= 4'h0;
      first <= 1'b1;
      sda_oe <= 1'b0;
    end else if (!ps && scl) begin
      if (cnt < 4'h8) sh <= {sh[6:0], sda};
      cnt <= cnt + 4'h1;
    end else if (ps && !scl && cnt == 4'h8) begin
      sda_oe <= first ? (sh[7:1] == ADDR) : !sh[0]; // data with bit0 set is refused
      last_byte <= sh;
    end else if (ps && !scl && cnt == 4'h9) begin
      sda_oe <= 1'b0;
      cnt <= 4'h0;
      first <= 1'b0;
    end
  end
endmodule // tmx_slave_model
`default_nettype wire

// ### tb/tb.sv
// testbench for the two-wire master transmitter
`timescale 1ns/100ps
`default_nettype none
`include "tmx_consts.svh"
module tb;
  localparam logic [6:0] SA = 7'h2a;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, re;
  logic scl_out, scl_oe, sda_out, sda_oe, rx_mode, s_oe, x_oe;
  logic [7:0]  paddr, last_byte;
  logic [31:0] pwdata, prdata, rq;
  int error_cnt, tests_run;
  wire scl = !(scl_oe && !scl_out);
  // x_oe stands for a competing master on the data line
  wire sda = !((sda_oe && !sda_out) || s_oe || x_oe);
  tmx_master #(.QTR_CYC(2)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .scl_in(scl),
    .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda), .sda_out(sda_out),
    .sda_oe(sda_oe), .rx_mode(rx_mode));
  tmx_slave_model #(.ADDR(SA)) sl_u (.pclk(pclk), .scl(scl), .sda(sda),
    .sda_oe(s_oe), .last_byte(last_byte));
  always #50 pclk = !pclk;
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch at %0t got %h exp %h", $time, g, e);
    end
  endtask
  // one apb transfer, held until pready is seen high
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rq = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic cmd(input logic [7:0] c, input logic [7:0] st);
    xfer(1'b1, `TMX_OFS_CTRL, {24'h0, c});
    rq = 32'h0;
    while (rq[7] !== 1'b1) xfer(1'b0, `TMX_OFS_CTRL, 32'h0);
    repeat (6) @(posedge pclk);
    // a lost arbitration releases the clock line instead of holding it
    chk(scl_oe, {31'h0, st != `TMX_ST_LOST});
    xfer(1'b0, `TMX_OFS_STAT, 32'h0);
    chk(rq & 32'hf8, {24'h0, st});
  endtask
  task automatic stop_chk(input logic [7:0] c);
    xfer(1'b1, `TMX_OFS_CTRL, {24'h0, c});
    repeat (100) @(posedge pclk);
    xfer(1'b0, `TMX_OFS_CTRL, 32'h0);
    chk(rq & 32'h90, 32'h0);
    chk({scl_oe, sda_oe}, 2'b00);
  endtask
  task automatic t_reset;
    xfer(1'b0, `TMX_OFS_CTRL, 32'h0);
    chk(rq, 32'h0);
    xfer(1'b0, `TMX_OFS_STAT, 32'h0);
    chk(rq & 32'hf8, 32'hf8);
    // prescaler left nonzero so every later status compare must really mask it
    xfer(1'b1, `TMX_OFS_STAT, 32'h3);
    xfer(1'b0, `TMX_OFS_STAT, 32'h0);
    chk(rq, 32'hfb);
    chk({scl_oe, sda_oe, rx_mode}, 3'b000);
    $display("reset test done");
  endtask
  task automatic t_wcol;
    xfer(1'b1, `TMX_OFS_DATA, 32'h33);
    xfer(1'b0, `TMX_OFS_DATA, 32'h0);
    chk(rq, {24'h0, `TMX_DATA_RST});
    xfer(1'b0, `TMX_OFS_CTRL, 32'h0);
    chk(rq & 32'h08, 32'h08);
    $display("collision test done");
  endtask
  // address, data ack and nak, repeated start, refused address
  task automatic t_write;
    cmd(8'ha4, `TMX_ST_START);
    xfer(1'b1, `TMX_OFS_DATA, {24'h0, SA, 1'b0});
    cmd(8'h84, `TMX_ST_AACK);
    chk(last_byte, {SA, 1'b0});
    xfer(1'b1, `TMX_OFS_DATA, 32'h5a);
    cmd(8'h84, `TMX_ST_DACK);
    chk(last_byte, 8'h5a);
    xfer(1'b1, `TMX_OFS_DATA, 32'h5b);
    cmd(8'h84, `TMX_ST_DNAK);
    cmd(8'ha4, `TMX_ST_RSTART);
    xfer(1'b1, `TMX_OFS_DATA, {24'h0, SA ^ 7'h01, 1'b0});
    cmd(8'h84, `TMX_ST_ANAK);
    chk(rx_mode, 1'b0);
    xfer(1'b1, `TMX_OFS_DATA, 32'h3c);
    cmd(8'h84, `TMX_ST_DACK);
    cmd(8'hb4, `TMX_ST_START);
    xfer(1'b0, `TMX_OFS_CTRL, 32'h0);
    chk(rq & 32'h10, 32'h0);
    stop_chk(8'h94);
    $display("transmit test done");
  endtask
  task automatic t_read;
    cmd(8'ha4, `TMX_ST_START);
    xfer(1'b1, `TMX_OFS_DATA, {24'h0, SA, 1'b1});
    cmd(8'h84, `TMX_ST_RAACK);
    chk(rx_mode, 1'b1);
    stop_chk(8'h94);
    xfer(1'b0, 8'h0c, 32'h0);
    chk(rq, 32'h0);
    chk({31'h0, re}, 32'h1);
    $display("receive test done");
  endtask
  // a second master holds the data line low while a one is sent
  task automatic t_lost;
    cmd(8'ha4, `TMX_ST_START);
    x_oe <= 1'b1;
    xfer(1'b1, `TMX_OFS_DATA, 32'hd4);
    cmd(8'h84, `TMX_ST_LOST);
    chk({scl_oe, sda_oe, rx_mode}, 3'b000);
    x_oe <= 1'b0;
    cmd(8'ha4, `TMX_ST_START);
    stop_chk(8'h94);
    $display("arbitration test done");
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // watchdog sized well above the whole sequence
  initial begin
    #3000000;
    error_cnt++;
    report_and_stop();
  end
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite} = 3'b000;
    x_oe = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_wcol();
    t_write();
    t_read();
    t_lost();
    report_and_stop();
  end
endmodule // tb
`default_nettype wire
